// ==== bench/cssu_checker.sv ====
// Assertion checker for the clock source selector.
// Assumes it is bound into cssu_top and sees only its ports.
`default_nettype none
module cssu_checker
    import cssu_pkg::*;
#(
    parameter int TO_SHORT = 512,
    parameter int TO_LONG  = 8192
) (
    input wire logic         clk_i,
    input wire logic         rstn_i,
    input wire cssu_fuse_t   fuse_i,
    input wire logic         src_tick_i,
    input wire logic         wdt_tick_i,
    input wire logic         wake_i,
    input wire cssu_av_req_t av_req_i,
    input wire cssu_av_rsp_t av_rsp_o,
    input wire cssu_osc_t    osc_o,
    input wire cssu_state_t  state_o
);
    // Ticks seen in the current state; the total shows on the first cycle of the next state
    cssu_state_t st_r;
    logic [15:0] cnt_r;
    logic        leave;
    assign leave = state_o != st_r;
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_r  <= ST_LOAD;
            cnt_r <= 16'h0000;
        end else begin
            st_r  <= state_o;
            cnt_r <= (leave ? 16'h0000 : cnt_r) + 16'((state_o == ST_TOUT) ? wdt_tick_i : src_tick_i);
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    chk_wdt_runs: assert property (osc_o.wdt_en)
        else $error("watchdog oscillator stopped");
    chk_rst14_len: assert property (leave && st_r == ST_RST14 |-> cnt_r == 14)
        else $error("reset delay not 14 source ticks");
    // A one-cycle visit means no time-out was chosen or the option was refused; a watchdog tick in that cycle is not counted by the design
    chk_tout_len: assert property (leave && st_r == ST_TOUT |-> cnt_r inside {TO_SHORT, TO_LONG} || $past(leave))
        else $error("reset time-out length wrong");
    chk_wake_len: assert property (leave && st_r == ST_WAKE && state_o == ST_RUN |-> cnt_r inside {6, 258, 1024, 16384})
        else $error("wake length wrong");
    chk_bad_gated: assert property (state_o == ST_BAD |-> !osc_o.clk_en && !(osc_o.rc_en | osc_o.lf_en | osc_o.xtal_en))
        else $error("clock running in refused option");
    chk_clk_cause: assert property (osc_o.clk_en |-> $past(src_tick_i) && $past(state_o) == ST_RUN)
        else $error("clock enable without source tick");
    chk_one_source: assert property ($onehot0({osc_o.rc_en, osc_o.lf_en, osc_o.xtal_en}))
        else $error("more than one source enabled");
    chk_amp_mode: assert property (osc_o.xtal_en |-> osc_o.amp_mode[2])
        else $error("crystal with bad amplifier mode");
    chk_fuse_cal: assert property (leave && st_r == ST_LOAD |-> ##[0:1] osc_o.cal == fuse_i.cal)
        else $error("calibration not loaded");
    chk_bus_answer: assert property ((av_req_i.read || av_req_i.write) && av_rsp_o.waitrequest |=> !av_rsp_o.waitrequest)
        else $error("bus answer late");
    chk_wait_pulse: assert property (!av_rsp_o.waitrequest |=> av_rsp_o.waitrequest)
        else $error("waitrequest low too long");

    cover property (leave && st_r == ST_WAKE && state_o == ST_RUN);
    cover property (state_o == ST_BAD && wake_i);
    cover property (osc_o.clk_en && osc_o.xtal_en);
endmodule

bind cssu_top cssu_checker #(.TO_SHORT(TO_SHORT), .TO_LONG(TO_LONG)) u_chk (.clk_i(clk_i), .rstn_i(rstn_i),
    .fuse_i(fuse_i), .src_tick_i(src_tick_i), .wdt_tick_i(wdt_tick_i), .wake_i(wake_i), .av_req_i(av_req_i),
    .av_rsp_o(av_rsp_o), .osc_o(osc_o), .state_o(state_o));
`default_nettype wire

// ==== bench/cssu_osc_model.sv ====
// Behavioural oscillators behind the clock source selector.
// Assumes ticks are sampled by the selector on the rising edge of clk_i.
`default_nettype none
module cssu_osc_model
    import cssu_pkg::*;
(
    input  wire logic      clk_i,
    input  wire logic      rstn_i,
    input  wire cssu_osc_t osc_i,
    input  wire logic      slow_i,
    output var  logic      src_tick_o,
    output var  logic      wdt_tick_o
);
    logic [2:0] src_q;
    logic [1:0] wdt_q;

    // A stopped source gives no edges at all; slow mode stretches the source period
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            src_q      <= 3'h0;
            wdt_q      <= 2'h0;
            src_tick_o <= 1'b0;
            wdt_tick_o <= 1'b0;
        end else begin
            src_q      <= (src_q >= (slow_i ? 3'h4 : 3'h1)) ? 3'h0 : src_q + 3'h1;
            src_tick_o <= (osc_i.rc_en | osc_i.lf_en | osc_i.xtal_en) && src_q == 3'h0;
            wdt_q      <= wdt_q + 2'h1;
            wdt_tick_o <= osc_i.wdt_en && wdt_q == 2'h0;
        end
    end
endmodule
`default_nettype wire

// ==== bench/tb.sv ====
// Self-checking bench of the clock source selector.
// Assumes the oscillator model supplies all ticks.
`default_nettype none
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin errors++; \
    $display("MISMATCH %s exp %0h got %0h", nm, ex, got); end end
module tb
    import cssu_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TS = 4;
    localparam int TL = 8;
    logic         clk_i, rstn_i, wake_i, slow, src_tick, wdt_tick;
    cssu_fuse_t   fuse;
    cssu_av_req_t req;
    cssu_av_rsp_t rsp;
    cssu_osc_t    osc;
    cssu_state_t  st, st_q;
    int           errors, n_checks, cyc, cnt, last_cnt;

    cssu_top #(.TO_SHORT(TS), .TO_LONG(TL)) dut (.clk_i(clk_i), .rstn_i(rstn_i), .fuse_i(fuse),
        .src_tick_i(src_tick), .wdt_tick_i(wdt_tick), .wake_i(wake_i), .av_req_i(req), .av_rsp_o(rsp),
        .osc_o(osc), .state_o(st));
    cssu_osc_model u_osc (.clk_i(clk_i), .rstn_i(rstn_i), .osc_i(osc), .slow_i(slow),
        .src_tick_o(src_tick), .wdt_tick_o(wdt_tick));

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    // Ticks per state, kept apart from the design so the figures are independent
    always @(posedge clk_i) begin
        cyc  <= cyc + 1;
        cnt  <= ((st !== st_q) ? 0 : cnt) + int'((st == ST_TOUT) ? wdt_tick : src_tick);
        if (st !== st_q) last_cnt <= cnt;
        st_q <= st;
        if (cyc == 100000) begin
            errors++;
            print_verdict();
        end
    end

    task print_verdict;
        $display("Checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task av(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        req <= '{read: ~wr, write: wr, address: a, writedata: d, byteenable: 4'hF};
        do @(posedge clk_i); while (rsp.waitrequest !== 1'b0);
        q = rsp.readdata;
        req <= '0;
    endtask

    task wait_st(input cssu_state_t s);
        for (int i = 0; i < 40000 && st !== s; i++) @(posedge clk_i);
        @(posedge clk_i);
    endtask

    task boot(input cssu_fuse_t f, input logic sl);
        @(posedge clk_i) rstn_i <= 1'b0;
        fuse <= f;
        slow <= sl;
        repeat (8) @(posedge clk_i);
        rstn_i <= 1'b1;
    endtask

    task sel_code(input logic [3:0] s, input logic [1:0] u, input cssu_state_t es, input int wk);
        logic [31:0] q;
        av(1'b1, 4'h0, {25'h0, 1'b0, u, s}, q);
        if (st === ST_RUN) begin
            av(1'b1, 4'hC, 32'h00000001, q);
            wait_st(ST_SLEEP);
        end
        @(posedge clk_i) wake_i <= 1'b1;
        @(posedge clk_i) wake_i <= 1'b0;
        wait_st(es);
        `CHK("wake state", es, st)
        if (es == ST_RUN) begin
            `CHK("wake ticks", wk, last_cnt)
            `CHK("xtal mode", {s[3], s[3:1]}, {osc.xtal_en, osc.amp_mode})
            `CHK("internal src", {s == 4'h2, s == 4'h3}, {osc.rc_en, osc.lf_en})
        end
    endtask

    task t_boot_rc;
        logic [31:0] q;
        boot('{sel: 4'h2, startup_time_fuses: 2'h1, div8: 1'b0, rstdis: 1'b0, cal: 8'h5A}, 1'b0);
        wait_st(ST_RST14);
        `CHK("short timeout", TS, last_cnt)
        wait_st(ST_RUN);
        `CHK("reset ticks", 14, last_cnt)
        av(1'b0, 4'h0, 32'h0, q);
        `CHK("select copy", 32'h00000012, q)
        av(1'b0, 4'h4, 32'h0, q);
        `CHK("cal copy", 32'h0000005A, q)
        `CHK("cal out", 8'h5A, osc.cal)
        av(1'b1, 4'h4, 32'h000000A7, q);
        av(1'b0, 4'h4, 32'h0, q);
        `CHK("cal write", 32'h000000A7, q)
        `CHK("cal follows", 8'hA7, osc.cal)
        av(1'b0, 4'h2, 32'h0, q);
        `CHK("unmapped", 32'h0, q)
        $display("t_boot_rc done");
    endtask

    task t_wake;
        sel_code(4'h3, 2'h0, ST_RUN, 6);
        sel_code(4'h8, 2'h0, ST_RUN, 258);
        sel_code(4'hA, 2'h1, ST_RUN, 258);
        sel_code(4'hC, 2'h2, ST_RUN, 1024);
        sel_code(4'hE, 2'h3, ST_RUN, 1024);
        sel_code(4'h9, 2'h0, ST_RUN, 1024);
        sel_code(4'h9, 2'h1, ST_RUN, 16384);
        sel_code(4'h2, 2'h3, ST_BAD, 0);
        sel_code(4'h2, 2'h0, ST_RUN, 6);
        $display("t_wake done");
    endtask

    task t_rstdis;
        logic [31:0] q;
        boot('{sel: 4'h2, startup_time_fuses: 2'h0, div8: 1'b0, rstdis: 1'b0, cal: 8'h11}, 1'b0);
        wait_st(ST_RUN);
        `CHK("14CK allowed", ST_RUN, st)
        boot('{sel: 4'h2, startup_time_fuses: 2'h0, div8: 1'b0, rstdis: 1'b1, cal: 8'h11}, 1'b0);
        wait_st(ST_BAD);
        `CHK("14CK refused", ST_BAD, st)
        av(1'b0, 4'h8, 32'h0, q);
        `CHK("status bad", 5'h16, q[4:0])
        $display("t_rstdis done");
    endtask

    task t_div8;
        int t, e;
        boot('{sel: 4'h2, startup_time_fuses: 2'h2, div8: 1'b1, rstdis: 1'b0, cal: 8'h00}, 1'b1);
        wait_st(ST_RST14);
        `CHK("long timeout", TL, last_cnt)
        wait_st(ST_RUN);
        t = 0;
        e = 0;
        while (t < 20) begin
            @(posedge clk_i);
            t += int'(src_tick === 1'b1);
            e += int'(osc.clk_en === 1'b1);
        end
        @(posedge clk_i);
        e += int'(osc.clk_en === 1'b1);
        `CHK("div8 pulses", 2, e)
        $display("t_div8 done");
    endtask

    initial begin
        req = '0;
        fuse = '0;
        wake_i = 1'b0;
        slow = 1'b0;
        rstn_i = 1'b0;
        errors = 0;
        n_checks = 0;
        cyc = 0;
        cnt = 0;
        last_cnt = 0;
        st_q = ST_LOAD;
        t_boot_rc();
        t_wake();
        t_rstdis();
        t_div8();
        print_verdict();
    end
endmodule
`default_nettype wire

// ==== hw/cssu_pkg.sv ====
// Types of the clock source and start-up selector.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package cssu_pkg;

    typedef enum logic [2:0] {
        ST_LOAD  = 3'b000,
        ST_TOUT  = 3'b001,
        ST_RST14 = 3'b010,
        ST_RUN   = 3'b011,
        ST_SLEEP = 3'b100,
        ST_WAKE  = 3'b101,
        ST_BAD   = 3'b110
    } cssu_state_t;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [3:0]  address;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } cssu_av_req_t;

    typedef struct packed {
        logic        waitrequest;
        logic [31:0] readdata;
    } cssu_av_rsp_t;

    typedef struct packed {
        logic [3:0] sel;
        logic [1:0] startup_time_fuses;
        logic       div8;
        logic       rstdis;
        logic [7:0] cal;
    } cssu_fuse_t;

    typedef struct packed {
        logic       rc_en;
        logic       lf_en;
        logic       xtal_en;
        logic [2:0] amp_mode;
        logic [7:0] cal;
        logic       wdt_en;
        logic       clk_en;
    } cssu_osc_t;

    typedef struct packed {
        logic        valid;
        logic [14:0] wake;
        logic [1:0]  tout;
    } cssu_opt_t;

endpackage
`default_nettype wire

// ==== hw/cssu_regs.svh ====
// Constants of the clock source and start-up selector: offsets, fields, counts.
// Assumes a byte-addressed Avalon-MM slave with 32-bit data words.
`ifndef CSSU_REGS_SVH
`define CSSU_REGS_SVH

// ********************************************************
// Register offsets
// ********************************************************
`define CSSU_SEL_OFS    4'h0
`define CSSU_CAL_OFS    4'h4
`define CSSU_STAT_OFS   4'h8
`define CSSU_CMD_OFS    4'hC

// ********************************************************
// Fields
// ********************************************************
`define CSSU_SEL_LSB    0
`define CSSU_SUT_LSB    4
`define CSSU_DIV8_BIT   6
`define CSSU_SLEEP_BIT  0
`define CSSU_CAL_RST    8'h00

// ********************************************************
// Source codes and counts
// ********************************************************
`define CSSU_CODE_RC    4'h2
`define CSSU_CODE_LF    4'h3
`define CSSU_RST_CK     14
`define CSSU_WAKE_INT   6
`define CSSU_WAKE_258   258
`define CSSU_WAKE_1K    1024
`define CSSU_WAKE_16K   16384
`define CSSU_TO_SHORT   512
`define CSSU_TO_LONG    8192

`endif

// ==== hw/cssu_top.sv ====
// Clock source select and start-up sequencer with an Avalon-MM register port.
// Assumes source and watchdog ticks are one-cycle pulses synchronous to clk_i.
//
// Chosen here: the Avalon-MM register port and the address map.
`default_nettype none
`include "cssu_regs.svh"

module cssu_top
    import cssu_pkg::*;
#(
    parameter int TO_SHORT = `CSSU_TO_SHORT,
    parameter int TO_LONG  = `CSSU_TO_LONG
) (
    input  wire logic         clk_i,
    input  wire logic         rstn_i,
    input  wire cssu_fuse_t   fuse_i,
    input  wire logic         src_tick_i,
    input  wire logic         wdt_tick_i,
    input  wire logic         wake_i,
    input  wire cssu_av_req_t av_req_i,
    output var  cssu_av_rsp_t av_rsp_o,
    output var  cssu_osc_t    osc_o,
    output var  cssu_state_t  state_o
);

    // ********************************************************
    // State
    // ********************************************************
    typedef struct packed {
        cssu_state_t  st;
        logic [3:0]   sel;
        logic [1:0]   startup_time_fuses;
        logic         div8;
        logic         rstdis;
        logic [14:0]  cnt;
        logic [2:0]   dcnt;
        cssu_osc_t    osc;
        cssu_av_rsp_t rsp;
    } cssu_regs_t;

    cssu_regs_t r;
    cssu_regs_t r_nxt;

    // ********************************************************
    // Option decode
    // ********************************************************
    // tout: 0 none, 1 short, 2 long
    // Crystal options by {select bit 0, start-up code}:
    //   0 00: 258 wake, short time-out
    //   0 01: 258 wake, long time-out
    //   0 10: 1024 wake, no time-out
    //   0 11: 1024 wake, short time-out
    //   1 00: 1024 wake, long time-out
    //   1 01: 16384 wake, no time-out
    //   1 10: 16384 wake, short time-out
    //   1 11: 16384 wake, long time-out
    // Options without a time-out are refused while the reset pin is disabled,
    // since nothing else would then guard the supply ramp.
    function automatic cssu_opt_t decode(
        input logic [3:0] sel,
        input logic [1:0] startup_time_fuses,
        input logic       rstdis
    );
        cssu_opt_t o;
        o.valid = 1'b1;
        o.wake  = 15'(`CSSU_WAKE_INT);
        o.tout  = startup_time_fuses;
        if (sel == `CSSU_CODE_RC || sel == `CSSU_CODE_LF) begin
            if (startup_time_fuses == 2'b11) begin
                o.valid = 1'b0;
            end
        end else if (sel[3]) begin
            case ({sel[0], startup_time_fuses})
                3'b000: begin
                    o.wake = 15'(`CSSU_WAKE_258);
                    o.tout = 2'd1;
                end
                3'b001: begin
                    o.wake = 15'(`CSSU_WAKE_258);
                    o.tout = 2'd2;
                end
                3'b010: begin
                    o.wake = 15'(`CSSU_WAKE_1K);
                    o.tout = 2'd0;
                end
                3'b011: begin
                    o.wake = 15'(`CSSU_WAKE_1K);
                    o.tout = 2'd1;
                end
                3'b100: begin
                    o.wake = 15'(`CSSU_WAKE_1K);
                    o.tout = 2'd2;
                end
                3'b101: begin
                    o.wake = 15'(`CSSU_WAKE_16K - 1);
                    o.tout = 2'd0;
                end
                3'b110: begin
                    o.wake = 15'(`CSSU_WAKE_16K - 1);
                    o.tout = 2'd1;
                end
                default: begin
                    o.wake = 15'(`CSSU_WAKE_16K - 1);
                    o.tout = 2'd2;
                end
            endcase
        end else begin
            // External clock and low-frequency crystal are not served here
            o.valid = 1'b0;
        end
        if (rstdis && o.tout == 2'd0) begin
            o.valid = 1'b0;
        end
        return o;
    endfunction

    // 16384 is stored in the 15-bit field as its last index; the other wake counts are reduced by one here
    function automatic logic [14:0] last_idx(input cssu_opt_t o);
        logic [14:0] v;
        v = (o.wake == 15'(`CSSU_WAKE_16K - 1)) ? o.wake : o.wake - 15'h0001;
        return v;
    endfunction

    // ********************************************************
    // Source enables
    // ********************************************************
    function automatic cssu_osc_t src_enables(
        input cssu_osc_t  cur,
        input logic [3:0] sel,
        input logic       on
    );
        cssu_osc_t o;
        o          = cur;
        o.rc_en    = on && sel == `CSSU_CODE_RC;
        o.lf_en    = on && sel == `CSSU_CODE_LF;
        o.xtal_en  = on && sel[3];
        o.amp_mode = sel[3:1];
        return o;
    endfunction

    cssu_opt_t opt;
    logic      req;
    logic      acc;
    logic      wr_lane;
    logic [31:0] rd_val;

    assign opt     = decode(r.sel, r.startup_time_fuses, r.rstdis);
    assign req     = av_req_i.read || av_req_i.write;
    assign acc     = req && !r.rsp.waitrequest;
    assign wr_lane = av_req_i.write && av_req_i.byteenable[0] && acc;

    // ********************************************************
    // Read mux
    // ********************************************************
    always_comb begin
        rd_val = 32'h0000_0000;
        case (av_req_i.address)
            `CSSU_SEL_OFS: begin
                rd_val[`CSSU_SEL_LSB +: 4] = r.sel;
                rd_val[`CSSU_SUT_LSB +: 2] = r.startup_time_fuses;
                rd_val[`CSSU_DIV8_BIT]     = r.div8;
            end
            `CSSU_CAL_OFS: begin
                rd_val[7:0] = r.osc.cal;
            end
            `CSSU_STAT_OFS: begin
                rd_val[2:0] = r.st;
                rd_val[3]   = r.osc.clk_en;
                rd_val[4]   = !opt.valid;
            end
            default: begin
                rd_val = 32'h0000_0000;
            end
        endcase
    end

    // ********************************************************
    // Next state
    // ********************************************************
    always_comb begin
        r_nxt            = r;
        r_nxt.osc.wdt_en = 1'b1;
        r_nxt.osc.clk_en = 1'b0;

        // Answer one cycle after the request is seen, for exactly one cycle
        r_nxt.rsp.waitrequest = !(req && r.rsp.waitrequest);
        if (req && r.rsp.waitrequest && av_req_i.read) begin
            r_nxt.rsp.readdata = rd_val;
        end

        if (wr_lane) begin
            case (av_req_i.address)
                `CSSU_SEL_OFS: begin
                    // Source and start-up code take effect at the next wake; div8 takes effect at once, mid-run
                    r_nxt.sel  = av_req_i.writedata[`CSSU_SEL_LSB +: 4];
                    r_nxt.startup_time_fuses  = av_req_i.writedata[`CSSU_SUT_LSB +: 2];
                    r_nxt.div8 = av_req_i.writedata[`CSSU_DIV8_BIT];
                end
                `CSSU_CAL_OFS: begin
                    r_nxt.osc.cal = av_req_i.writedata[7:0];
                end
                default: begin
                end
            endcase
        end

        case (r.st)
            ST_LOAD: begin
                // Fuses are straps, caught on the first clock after reset
                r_nxt.sel     = fuse_i.sel;
                r_nxt.startup_time_fuses     = fuse_i.startup_time_fuses;
                r_nxt.div8    = fuse_i.div8;
                r_nxt.rstdis  = fuse_i.rstdis;
                r_nxt.osc.cal = fuse_i.cal;
                r_nxt.cnt     = 15'h0000;
                r_nxt.st      = ST_TOUT;
            end
            ST_TOUT: begin
                r_nxt.osc = src_enables(r_nxt.osc, r.sel, opt.valid);
                if (!opt.valid) begin
                    r_nxt.st = ST_BAD;
                end else if (opt.tout == 2'd0) begin
                    r_nxt.st  = ST_RST14;
                    r_nxt.cnt = 15'h0000;
                end else if (wdt_tick_i) begin
                    r_nxt.cnt = r.cnt + 15'h0001;
                    if ((opt.tout == 2'd1 && r.cnt == 15'(TO_SHORT - 1)) ||
                        (opt.tout == 2'd2 && r.cnt == 15'(TO_LONG - 1))) begin
                        r_nxt.st  = ST_RST14;
                        r_nxt.cnt = 15'h0000;
                    end
                end
            end
            ST_RST14: begin
                if (src_tick_i) begin
                    r_nxt.cnt = r.cnt + 15'h0001;
                    if (r.cnt == 15'(`CSSU_RST_CK - 1)) begin
                        r_nxt.st   = ST_RUN;
                        r_nxt.dcnt = 3'h0;
                    end
                end
            end
            ST_RUN: begin
                if (src_tick_i) begin
                    r_nxt.dcnt       = r.dcnt + 3'h1;
                    r_nxt.osc.clk_en = !r.div8 || r.dcnt == 3'h7;
                end
                if (wr_lane && av_req_i.address == `CSSU_CMD_OFS &&
                    av_req_i.writedata[`CSSU_SLEEP_BIT]) begin
                    r_nxt.st         = ST_SLEEP;
                    r_nxt.osc.clk_en = 1'b0;
                end
            end
            ST_SLEEP: begin
                r_nxt.osc = src_enables(r_nxt.osc, r.sel, 1'b0);
                if (wake_i) begin
                    r_nxt.osc = src_enables(r_nxt.osc, r.sel, opt.valid);
                    r_nxt.cnt = 15'h0000;
                    r_nxt.st  = opt.valid ? ST_WAKE : ST_BAD;
                end
            end
            ST_WAKE: begin
                if (src_tick_i) begin
                    r_nxt.cnt = r.cnt + 15'h0001;
                    if (r.cnt == last_idx(opt)) begin
                        r_nxt.st   = ST_RUN;
                        r_nxt.dcnt = 3'h0;
                    end
                end
            end
            ST_BAD: begin
                // Refused option: clock stays gated until software fixes the code and a wake arrives
                r_nxt.osc = src_enables(r_nxt.osc, r.sel, 1'b0);
                if (wake_i && opt.valid) begin
                    r_nxt.osc = src_enables(r_nxt.osc, r.sel, 1'b1);
                    r_nxt.cnt = 15'h0000;
                    r_nxt.st  = ST_WAKE;
                end
            end
            default: begin
                r_nxt.st = ST_LOAD;
            end
        endcase
    end

    // ********************************************************
    // Registers
    // ********************************************************
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            r                 <= '0;
            r.st              <= ST_LOAD;
            r.sel             <= `CSSU_CODE_RC;
            r.startup_time_fuses             <= 2'b10;
            r.div8            <= 1'b1;
            r.osc.cal         <= `CSSU_CAL_RST;
            r.osc.wdt_en      <= 1'b1;
            r.rsp.waitrequest <= 1'b1;
        end else begin
            r <= r_nxt;
        end
    end

    assign av_rsp_o = r.rsp;
    assign osc_o    = r.osc;
    assign state_o  = r.st;

endmodule
`default_nettype wire
